// ===== hdl/pcint_cfg.svh
// Register map, field positions and reset values of the pin-change unit
`ifndef PCINT_CFG_SVH
`define PCINT_CFG_SVH
// ==========================================================================
// Register offsets
`define OFS_MASK0 8'h6B
`define OFS_MASK1 8'h6C
`define OFS_MASK2 8'h6D
`define OFS_CONTROL 8'h68
`define OFS_FLAGS 8'h3B
`define OFS_IRQ_MASK 8'h70
// ==========================================================================
// Field layout
`define GRP_BITS 3
`define MASK1_USED 8'h7F
`define GROUP_BITS_MASK 8'h07
`define REG_RESET 8'h00
`define GRP_RESET 3'h0
`endif

// ===== hdl/pcint_pkg.sv
// Types shared by the pin-change interrupt unit
package pcint_pkg;
   // Register bus request bundle
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;
   // Dispatch interface to the processor
   typedef struct packed {
      logic [2:0] ack;
      logic global_enable;
   } cpu_ctl_t;
endpackage

// ===== hdl/pin_change_interrupt_unit.sv
// Pin-change interrupt unit: three pin groups, masks, flags and dispatch
//
// Operation
// R1: Group 0 requests need enable and global enable
// R2: Group 0 requests use group 0 vector
// R3: Flag register bits 7..3 read zero
// R4: Group 2 change sets flag bit 2
// R5: Group 1 change sets flag bit 1
// R6: Group 0 change sets flag bit 0
// R7: Set flag plus enables vectors the processor
// R8: Vector entry clears the group flag
// R9: Writing one clears flag; zero keeps it
// R10: Group 2 mask at 0x6D gates pins 23..16
// R11: Group 1 mask at 0x6C gates pins 14..8
// R12: Group 1 mask bit 7 reads zero
// R13: Group 0 mask at 0x6B gates pins 7..0
// R14: Control bits 2..0 enable groups; 7..3 zero
// R15: Change is masked pin differing from previous
// R16: Reset clears masks, enables and flags
//
// The address-and-strobe port is this design's own decision.
`include "pcint_cfg.svh"

module pin_change_interrupt_unit #(
   parameter int G0_W = 8,
   parameter int G1_W = 7,
   parameter int G2_W = 8
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire pcint_pkg::bus_req_t bus,
   output logic [7:0] rdata,
   input wire logic [G0_W-1:0] group0_pins,
   input wire logic [G1_W-1:0] group1_pins,
   input wire logic [G2_W-1:0] group2_pins,
   input wire pcint_pkg::cpu_ctl_t cpu,
   output logic [2:0] vector_req,
   output logic irq
);
   // ======================================================================
   // Registers
   logic [7:0] mask0_r;
   logic [7:0] mask1_r;
   logic [7:0] mask2_r;
   logic [2:0] enable_r;
   logic [2:0] flags_r;
   logic [2:0] flags_nxt;
   logic [2:0] irq_mask_r;
   logic [7:0] rdata_r;
   logic [2:0] group_change;
   logic [2:0] clear_wr;
   logic [G0_W-1:0] p0_r;
   logic [G1_W-1:0] p1_r;
   logic [G2_W-1:0] p2_r;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mask0_r <= `REG_RESET; // R16
         mask1_r <= `REG_RESET;
         mask2_r <= `REG_RESET;
         enable_r <= `GRP_RESET;
         irq_mask_r <= `GRP_RESET;
      end else if (bus.wr) begin
         unique case (bus.addr)
            `OFS_MASK0: mask0_r <= bus.wdata; // R13
            `OFS_MASK1: mask1_r <= bus.wdata & `MASK1_USED; // R11 R12
            `OFS_MASK2: mask2_r <= bus.wdata; // R10
            `OFS_CONTROL: enable_r <= bus.wdata[2:0]; // R14
            `OFS_IRQ_MASK: irq_mask_r <= bus.wdata[2:0];
            default: ;
         endcase
      end
   end

   // ======================================================================
   // Change detection; pins are already synchronous to clk
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         p0_r <= '0;
         p1_r <= '0;
         p2_r <= '0;
      end else begin
         p0_r <= group0_pins;
         p1_r <= group1_pins;
         p2_r <= group2_pins;
      end
   end

   // Mask applies to the change, not the level, so unmasking a pin
   // that already differs does not fire by itself.
   always_comb begin
      group_change[0] = |((group0_pins ^ p0_r) & mask0_r[G0_W-1:0]); // R15
      group_change[1] = |((group1_pins ^ p1_r) & mask1_r[G1_W-1:0]);
      group_change[2] = |((group2_pins ^ p2_r) & mask2_r[G2_W-1:0]);
   end

   // ======================================================================
   // Flags: a change in the clear cycle wins over the clear
   always_comb begin
      clear_wr = '0;
      if (bus.wr && bus.addr == `OFS_FLAGS) begin
         clear_wr = bus.wdata[2:0]; // R9
      end
      flags_nxt = flags_r & ~clear_wr & ~cpu.ack; // R8
      flags_nxt = flags_nxt | group_change; // R4 R5 R6
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         flags_r <= `GRP_RESET; // R16
      end else begin
         flags_r <= flags_nxt;
      end
   end

   // ======================================================================
   // Dispatch: one request line per group vector
   always_comb begin
      vector_req = flags_r & enable_r & {3{cpu.global_enable}}; // R1 R2 R7
      irq = |(flags_r & irq_mask_r);
   end

   // ======================================================================
   // Read port, data one cycle after the strobe
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_r <= `REG_RESET;
      end else if (bus.rd) begin
         unique case (bus.addr)
            `OFS_MASK0: rdata_r <= mask0_r;
            `OFS_MASK1: rdata_r <= mask1_r & `MASK1_USED; // R12
            `OFS_MASK2: rdata_r <= mask2_r;
            `OFS_CONTROL: rdata_r <= {5'h0_0, enable_r}; // R14
            `OFS_FLAGS: rdata_r <= {5'h0_0, flags_r}; // R3
            `OFS_IRQ_MASK: rdata_r <= {5'h0_0, irq_mask_r};
            default: rdata_r <= `REG_RESET;
         endcase
      end else begin
         rdata_r <= `REG_RESET;
      end
   end

   assign rdata = rdata_r;
endmodule // pin_change_interrupt_unit

// ===== bench/pcint_assertions.sv
// Port checker of the pin-change interrupt unit
module pcint_assertions #(parameter int G0_W = 8, G1_W = 7, G2_W = 8) (
   input wire logic clk,
   input wire logic arst_n,
   input wire pcint_pkg::bus_req_t bus,
   input wire logic [7:0] rdata,
   input wire logic [G0_W-1:0] group0_pins,
   input wire logic [G1_W-1:0] group1_pins,
   input wire logic [G2_W-1:0] group2_pins,
   input wire pcint_pkg::cpu_ctl_t cpu,
   input wire logic [2:0] vector_req,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   idle_read_a: assert property (!bus.rd |=> rdata == 8'h00)
      else $error("rdata outside read");
   flag_high_a: assert property (bus.rd && bus.addr == 8'h3B
      |=> rdata[7:3] == 5'h00) else $error("flag upper bits");
   mask1_top_a: assert property (bus.rd && bus.addr == 8'h6C
      |=> !rdata[7]) else $error("mask1 bit 7");
   vector_gate_a: assert property (|vector_req |-> cpu.global_enable)
      else $error("vector without global enable");
   entry_clear_a: assert property (cpu.ack[1] && $stable(group1_pins)
      |=> !vector_req[1]) else $error("entry keeps flag");
   write_clear_a: assert property (bus.wr && bus.addr == 8'h3B
      && bus.wdata[0] && $stable(group0_pins) |=> !vector_req[0])
      else $error("write one keeps flag");
   no_change_a: assert property (cpu.global_enable && !vector_req[2]
      && !bus.wr && $stable(group2_pins) |=> !vector_req[2])
      else $error("flag without change");
   reset_quiet_a: assert property ($rose(arst_n)
      |-> vector_req == 3'h0 && !irq) else $error("outputs after reset");
endmodule // pcint_assertions
bind pin_change_interrupt_unit pcint_assertions
   #(.G0_W(G0_W), .G1_W(G1_W), .G2_W(G2_W)) chk (.*);

// ===== bench/cpu_model.sv
// Processor dispatch model: enters each requested vector once
module cpu_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [2:0] vector_req,
   output logic [2:0] ack
);
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n) ack <= 3'h0;
      else ack <= vector_req & ~ack;
endmodule // cpu_model

// ===== bench/tb_top.sv
// Self-checking bench for the pin-change interrupt unit
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, arst_n = 0, gie = 0, irq;
   logic [7:0] rdata, p0 = 0, p2 = 0;
   logic [6:0] p1 = 0;
   logic [2:0] vreq, ack;
   pcint_pkg::bus_req_t bus = '0;
   int error_cnt = 0, n_compared = 0, cyc = 0;
   // Address, write data, read-back
   logic [23:0] rows [7] = '{24'h6B_FFFF, 24'h6C_FF7F, 24'h6D_A5A5,
      24'h68_FF07, 24'h70_FF07, 24'h3B_FF00, 24'h55_FF00};
   pin_change_interrupt_unit dut (.clk(clk), .arst_n(arst_n), .bus(bus),
      .rdata(rdata), .group0_pins(p0), .group1_pins(p1), .group2_pins(p2),
      .cpu({ack, gie}), .vector_req(vreq), .irq(irq));
   cpu_model cpu_m (.clk(clk), .arst_n(arst_n), .vector_req(vreq),
      .ack(ack));
   task automatic chk(string n, logic [7:0] e, logic [7:0] s);
      n_compared++;
      if (s !== e) begin
         error_cnt++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk) bus <= '0;
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e);
      @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk) bus <= '0;
      #1 chk("rdata", e, rdata);
   endtask
   task automatic results;
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial forever #2.5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         error_cnt++;
         results();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      arst_n <= 1;
      foreach (rows[i]) begin
         rd(rows[i][23:16], 8'h00);
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16], rows[i][7:0]);
      end
      @(posedge clk) p0 <= 8'h01;
      @(posedge clk) #1 chk("vec irq", 8'h01, {vreq, irq});
      rd(8'h3B, 8'h01);
      wr(8'h3B, 8'h01);
      rd(8'h3B, 8'h00);
      @(posedge clk) p2 <= 8'h02;
      rd(8'h3B, 8'h00);
      @(posedge clk) {p1, p2} <= {7'h01, 8'h03};
      rd(8'h3B, 8'h06);
      @(posedge clk) gie <= 1;
      #1 chk("vec", 8'h06, {5'h00, vreq});
      repeat (2) @(posedge clk);
      rd(8'h3B, 8'h00);
      results();
   end
endmodule // tb_top
